// ==== sim/rbsd_assertions.sv ====
// port checker for the readback select decoder
// assumes it is bound into rbsd_top
`default_nettype none
module rbsd_assertions (
  input wire logic        SYS_CLK_I,
  input wire logic        RESETN_I,
  input wire logic        SYNC_N_I,
  input wire logic        SDO_OE_O,
  input wire logic [23:0] FRAME_O,
  input wire logic        FRAME_VALID_O,
  input wire logic        READSEL_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence sel_frame; FRAME_VALID_O && READSEL_O; endsequence
  sequence bus_idle; SYNC_N_I [*6]; endsequence
  chk_sel_in_frame: assert property (
    READSEL_O |-> FRAME_VALID_O) else $error("lone select");
  chk_sel_mode: assert property (
    sel_frame |-> FRAME_O[23:22] == 2'h0) else $error("select mode");
  chk_sel_code: assert property (
    sel_frame |-> FRAME_O[21:16] == 6'h05) else $error("select code");
  chk_nop_no_sel: assert property (
    FRAME_VALID_O && FRAME_O[21:16] != 6'h05 |-> !READSEL_O)
    else $error("false select");
  chk_mode_gate: assert property (
    FRAME_VALID_O && FRAME_O[23:22] != 2'h0 |-> !READSEL_O)
    else $error("data frame selected");
  chk_valid_pulse: assert property (
    FRAME_VALID_O |=> !FRAME_VALID_O) else $error("long valid");
  chk_frame_hold: assert property (
    FRAME_VALID_O |-> ##2 $stable(FRAME_O) [*6]) else $error("frame moved");
  chk_oe_in_frame: assert property (
    $rose(SDO_OE_O) |-> !SYNC_N_I) else $error("drive outside frame");
  chk_oe_released: assert property (
    bus_idle |-> !SDO_OE_O) else $error("drive when idle");
endmodule // rbsd_assertions
bind rbsd_top rbsd_assertions i_chk (.SYS_CLK_I, .RESETN_I, .SYNC_N_I,
  .SDO_OE_O, .FRAME_O, .FRAME_VALID_O, .READSEL_O);
`default_nettype wire

// ==== sim/rbsd_host.sv ====
// host spi master model, 200 ns link clock, msb first
// assumes the caller enters xfer just after a falling clock edge
`default_nettype none
module rbsd_host (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output var  logic sclk_o,
  output var  logic sync_n_o,
  output var  logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk_o = 1'b0;
    sync_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // link clock stands low between frames
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    // data moves on the rise and stands across the device's sampling fall
    sync_n_o = 1'b0;
    sdi_o = w[23];
    for (int i = 23; i >= 0; i--) begin
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
      sdi_o = w[i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
      r[i] = sdo_i;
    end
    repeat (4) @(negedge clk_i);
    sync_n_o = 1'b1;
    // released line must not keep showing the last bit
    sdi_o = ~sdi_o;
    repeat (8) @(negedge clk_i);
  endtask
endmodule // rbsd_host
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench: random register contents, every selection kind
// assumes rbsd_top, rbsd_host and the checker are compiled
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [511:0] xa, xb, of, gn;
  logic [15:0]  ct, lf, fld;
  logic [13:0]  o0, o1;
  logic [31:0]  bk;
  logic [23:0]  rd;
  int           error_cnt = 0;
  int           samples_checked = 0;
  int           cyc = 0;
  wire          sclk, sync_n, sdi, sdo;
  always #12.5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] expv(input logic [15:0] f);
    logic [4:0] c;
    c = 5'(f[12:7] - 6'h08);
    if (!f[15]) begin
      if (f[12:7] < 6'h08 || f[12:7] > 6'h27) return 16'h0;
      case (f[14:13])
        2'h0: return xa[16*c+:16];
        2'h1: return xb[16*c+:16];
        2'h2: return of[16*c+:16];
        default: return gn[16*c+:16];
      endcase
    end
    if (f[14:11] != 4'h0) return 16'h0;
    case (f[10:7])
      4'h1: return ct;
      4'h2: return {2'h0, o0};
      4'h3: return {2'h0, o1};
      4'h6, 4'h7, 4'h8, 4'h9: return {8'h0, bk[8*(f[10:7]-4'h6)+:8]};
      default: return 16'h0;
    endcase
  endfunction
  rbsd_top i_rbsd_top (.SYS_CLK_I(clk), .RESETN_I(rst_n), .SCLK_I(sclk),
    .SYNC_N_I(sync_n), .SDI_I(sdi), .X1A_DATA_I(xa), .X1B_DATA_I(xb),
    .OFFS_DATA_I(of), .GAIN_DATA_I(gn), .CTRL_DATA_I(ct), .OFFSET_DAC_ZERO_CODE_DATA_I(o0),
    .OFFSET_DAC_ONE_CODE_DATA_I(o1), .BANK_DATA_I(bk), .SDO_O(sdo), .SDO_OE_O(),
    .FRAME_O(), .FRAME_VALID_O(), .READSEL_O());
  rbsd_host i_host (.clk_i(clk), .sdo_i(sdo), .sclk_o(sclk),
    .sync_n_o(sync_n), .sdi_o(sdi));
  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    lf = 16'h1944;
    for (int i = 0; i < 128; i++) begin
      lf = lfsr(lf);
      {xa, xb, of, gn} = {xa[495:0], xb, of, gn, lf};
    end
    {ct, o0, o1, bk} = {lfsr(lf), lf[13:0], ~lf[13:0], lf, ~lf};
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    // channel ends, globals with reserved codes, then a bad channel
    for (int t = 0; t < 25; t++) begin
      lf = lfsr(lf);
      if (t < 12)
        fld = {1'b0, 2'(t), 6'(t % 3 == 0 ? 8 : t % 3 == 1 ? 39 :
          8 + lf[11:7]), lf[6:0]};
      else if (t < 24)
        fld = {5'h10, 4'(t - 12), lf[6:0]};
      else
        fld = {3'h1, 6'h00, lf[6:0]};
      i_host.xfer({8'h05, fld}, rd);
      i_host.xfer(24'h0, rd);
      samples_checked++;
      if (rd !== {8'h0, expv(fld)}) begin
        error_cnt++;
        $display("mismatch %0t field %h read %h", $time, fld, rd);
      end
    end
    // readback code under data-write mode bits must not arm
    i_host.xfer({2'h3, 6'h05, fld}, rd);
    i_host.xfer(24'h0, rd);
    samples_checked++;
    if (rd !== 24'h0) begin
      error_cnt++;
      $display("mismatch %0t data frame armed readback %h", $time, rd);
    end
    finish_test();
  end
endmodule // testbench
`default_nettype wire

// ==== src/rbsd_decode.v ====
// pure decode of the 16-bit readback selection field
// assumes the caller latches the result on a selection command
`include "rbsd_defs.vh"
`default_nettype none
module rbsd_decode (
  input  wire [15:0] field_i,
  output reg  [3:0]  sel_o,
  output reg  [1:0]  kind_o,
  output reg  [4:0]  chan_o,
  output reg  [1:0]  bank_o
);
  wire [2:0] kind = field_i[15:13];
  wire [5:0] code = field_i[12:7];
  wire [5:0] cidx = code - `RBSD_CHAN_BASE;

  // f6..f0 never reach this logic
  always @* begin
    sel_o  = `RBSD_SEL_NONE;
    kind_o = kind[1:0];
    chan_o = cidx[4:0];
    bank_o = 2'h0;
    if (kind[2] == 1'b0) begin
      if (code >= `RBSD_CHAN_BASE && code <= `RBSD_CHAN_LAST)
        sel_o = `RBSD_SEL_CHAN;
    end else if (kind == `RBSD_KIND_GLOBAL && field_i[12:11] == 2'h0) begin
      case (field_i[10:7])
        `RBSD_GL_CTRL: sel_o = `RBSD_SEL_CTRL;
        `RBSD_GL_OFFSET_DAC_ZERO_CODE: sel_o = `RBSD_SEL_OFFSET_DAC_ZERO_CODE;
        `RBSD_GL_OFFSET_DAC_ONE_CODE: sel_o = `RBSD_SEL_OFFSET_DAC_ONE_CODE;
        default: begin
          if (field_i[10:7] >= `RBSD_GL_BANK0 &&
              field_i[10:7] <= `RBSD_GL_BANK3) begin
            sel_o  = `RBSD_SEL_BANK;
            bank_o = field_i[8:7] - 2'h2;
          end
        end
      endcase
    end
  end
endmodule // rbsd_decode
`default_nettype wire

// ==== src/rbsd_defs.vh ====
// constants for the readback select decoder
// assumes 24-bit serial frames, mode bits at the top
`ifndef RBSD_DEFS_VH
`define RBSD_DEFS_VH
`define RBSD_FRAME_BITS     24
`define RBSD_MODE_HI        23
`define RBSD_MODE_LO        22
`define RBSD_MODE_SPECIAL   2'h0
`define RBSD_SF_MSB         21
`define RBSD_SF_LSB         16
`define RBSD_SF_NOP         6'h00
`define RBSD_SF_READSEL     6'h05
`define RBSD_KIND_X1A       3'h0
`define RBSD_KIND_X1B       3'h1
`define RBSD_KIND_OFFS      3'h2
`define RBSD_KIND_GAIN      3'h3
`define RBSD_KIND_GLOBAL    3'h4
`define RBSD_CHAN_BASE      6'h08
`define RBSD_CHAN_LAST      6'h27
`define RBSD_GL_CTRL        4'h1
`define RBSD_GL_OFFSET_DAC_ZERO_CODE        4'h2
`define RBSD_GL_OFFSET_DAC_ONE_CODE        4'h3
`define RBSD_GL_BANK0       4'h6
`define RBSD_GL_BANK3       4'h9
`define RBSD_SEL_NONE       4'h0
`define RBSD_SEL_CHAN       4'h1
`define RBSD_SEL_CTRL       4'h2
`define RBSD_SEL_OFFSET_DAC_ZERO_CODE       4'h3
`define RBSD_SEL_OFFSET_DAC_ONE_CODE       4'h4
`define RBSD_SEL_BANK       4'h5
`endif

// ==== src/rbsd_top.v ====
// readback select decoder: spi slave front end, selection latch,
// register fetch and msb-first shift-out on the following frame
// assumes register contents arrive as flat buses from the dac core
`include "rbsd_defs.vh"
`default_nettype none
// Notes on behaviour
// - a frame whose two mode bits are 00 is a special-function command.
// - bits 21..16 hold the function code; the readback code latches the field.
// - field bits 15..13 of 000..011 pick data a, data b, offset or gain.
// - 100 00 picks control, offset dac 0/1 codes or bank selects 0..3.
// - field bits 6..0 of a selection are ignored.
// - the next frame, a no-op, shifts out the selected register.
module rbsd_top (
  input  wire         SYS_CLK_I,
  input  wire         RESETN_I,
  input  wire         SCLK_I,
  input  wire         SYNC_N_I,
  input  wire         SDI_I,
  input  wire [511:0] X1A_DATA_I,
  input  wire [511:0] X1B_DATA_I,
  input  wire [511:0] OFFS_DATA_I,
  input  wire [511:0] GAIN_DATA_I,
  input  wire [15:0]  CTRL_DATA_I,
  input  wire [13:0]  OFFSET_DAC_ZERO_CODE_DATA_I,
  input  wire [13:0]  OFFSET_DAC_ONE_CODE_DATA_I,
  input  wire [31:0]  BANK_DATA_I,
  output reg          SDO_O,
  output reg          SDO_OE_O,
  output reg  [23:0]  FRAME_O,
  output reg          FRAME_VALID_O,
  output reg          READSEL_O
);
  // ****************
  // input sync
  // ****************
  reg [2:0] sclk_q;
  reg [1:0] sync_q;
  reg [1:0] sdi_q;
  always @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      sclk_q <= 3'h0;
      sync_q <= 2'h3;
      sdi_q  <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], SCLK_I};
      sync_q <= {sync_q[0], SYNC_N_I};
      sdi_q  <= {sdi_q[0], SDI_I};
    end
  end
  wire sclk_fall = sclk_q[2] & ~sclk_q[1];
  wire sclk_rise = ~sclk_q[2] & sclk_q[1];
  wire in_frame  = ~sync_q[1];

  // ****************
  // decode
  // ****************
  reg  [23:0] shin_q;
  reg  [4:0]  cnt_q;
  wire [3:0]  dsel;
  wire [1:0]  dkind;
  wire [4:0]  dchan;
  wire [1:0]  dbank;
  wire [23:0] word_d = {shin_q[22:0], sdi_q[1]};
  rbsd_decode u_dec (
    .field_i (word_d[15:0]),
    .sel_o   (dsel),
    .kind_o  (dkind),
    .chan_o  (dchan),
    .bank_o  (dbank)
  );

  function [15:0] pick16;
    input [511:0] v;
    input [4:0]   i;
    pick16 = v[{i, 4'h0} +: 16];
  endfunction

  // ****************
  // register fetch
  // ****************
  // channel data picked from flat buses; no local copy is kept
  // 14-bit and 8-bit registers are zero-padded to the 16-bit word
  reg [3:0]  sel_q;
  reg [1:0]  kind_q;
  reg [4:0]  chan_q;
  reg [1:0]  bank_q;
  reg [15:0] rd_val;
  always @* begin
    case (sel_q)
      `RBSD_SEL_CHAN: begin
        case (kind_q)
          2'h0:    rd_val = pick16(X1A_DATA_I, chan_q);
          2'h1:    rd_val = pick16(X1B_DATA_I, chan_q);
          2'h2:    rd_val = pick16(OFFS_DATA_I, chan_q);
          default: rd_val = pick16(GAIN_DATA_I, chan_q);
        endcase
      end
      `RBSD_SEL_CTRL: rd_val = CTRL_DATA_I;
      `RBSD_SEL_OFFSET_DAC_ZERO_CODE: rd_val = {2'h0, OFFSET_DAC_ZERO_CODE_DATA_I};
      `RBSD_SEL_OFFSET_DAC_ONE_CODE: rd_val = {2'h0, OFFSET_DAC_ONE_CODE_DATA_I};
      `RBSD_SEL_BANK: rd_val = {8'h00, BANK_DATA_I[{bank_q, 3'h0} +: 8]};
      default:        rd_val = 16'h0000;
    endcase
  end

  // ****************
  // frame engine
  // ****************
  // readback is zero-extended to the full 24-bit frame
  reg [23:0] shout_q;
  reg        armed_q;
  reg        sync_d1_q;
  // first cycle with the synced select low
  wire       frame_start = sync_d1_q & in_frame;
  wire       bit_fall    = sclk_fall & in_frame;
  wire       bit_rise    = sclk_rise & in_frame;
  wire       last_bit    = bit_fall &
                           (cnt_q == 5'd`RBSD_FRAME_BITS - 5'd1);
  // mode bits 00 mark a special function, never a data write
  wire       special     = word_d[`RBSD_MODE_HI:`RBSD_MODE_LO] ==
                           `RBSD_MODE_SPECIAL;
  wire [5:0] sfcode      = word_d[`RBSD_SF_MSB:`RBSD_SF_LSB];
  // only a complete special frame with the readback code selects
  wire       sel_hit     = last_bit & special &
                           (sfcode == `RBSD_SF_READSEL);

  // ****************
  // receive shifter
  // ****************
  // sdi passes the same two stages as sclk, so it lines up with the edge
  // a cut frame leaves its bits behind; the count restart hides them
  always @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      shin_q    <= 24'h000000;
      cnt_q     <= 5'h00;
      sync_d1_q <= 1'b1;
    end else begin
      sync_d1_q <= sync_q[1];
      if (!in_frame) begin
        cnt_q <= 5'h00;
      end else if (bit_fall) begin
        shin_q <= word_d;
        cnt_q  <= cnt_q + 5'd1;
      end
    end
  end

  // ****************
  // selection latch
  // ****************
  // the arm lasts for exactly one following frame, whatever it carries
  // reserved codes still latch, as none, so a read returns zeros
  always @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      sel_q   <= `RBSD_SEL_NONE;
      kind_q  <= 2'h0;
      chan_q  <= 5'h00;
      bank_q  <= 2'h0;
      armed_q <= 1'b0;
    end else begin
      if (frame_start) begin
        armed_q <= 1'b0;
      end
      if (sel_hit) begin
        sel_q   <= dsel;
        kind_q  <= dkind;
        chan_q  <= dchan;
        bank_q  <= dbank;
        armed_q <= 1'b1;
      end
    end
  end

  // ****************
  // frame report
  // ****************
  // one-cycle pulses; the word itself stands until the next frame ends
  always @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      FRAME_O       <= 24'h000000;
      FRAME_VALID_O <= 1'b0;
      READSEL_O     <= 1'b0;
    end else begin
      FRAME_VALID_O <= last_bit;
      READSEL_O     <= sel_hit;
      if (last_bit) begin
        FRAME_O <= word_d;
      end
    end
  end

  // ****************
  // transmit shifter
  // ****************
  // load before first rising edge so bit 23 is valid on capture
  // an unarmed frame keeps the pin released for a bus neighbour
  always @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      shout_q  <= 24'h000000;
      SDO_O    <= 1'b0;
      SDO_OE_O <= 1'b0;
    end else begin
      if (!in_frame) begin
        SDO_OE_O <= 1'b0;
      end
      if (frame_start) begin
        SDO_OE_O <= armed_q;
        SDO_O    <= 1'b0;
        shout_q  <= armed_q ? {8'h00, rd_val} : 24'h000000;
      end else if (bit_rise & SDO_OE_O) begin
        // shift on the rise so the host samples a settled bit on the fall
        SDO_O   <= shout_q[23];
        shout_q <= {shout_q[22:0], 1'b0};
      end
    end
  end
endmodule // rbsd_top
`default_nettype wire
